// ==== src/capture_compare_pwm_unit.sv ====
// capture/compare/pwm unit with an axi4-lite register file and two interrupt lines
// assumes: single clock, pin input asynchronous, converter start taken as a pulse
`timescale 1ns/1ps
module capture_compare_pwm_unit
    import ccp_pkg::*;
(
    input  wire logic              clock,           // system clock, 250 MHz
    input  wire logic              reset,           // sync reset, high
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // write address
    input  wire logic              s_axi_awvalid,   // write address valid
    output logic                   s_axi_awready,   // write address ready
    input  wire logic [31:0]       s_axi_wdata,     // write data
    input  wire logic [3:0]        s_axi_wstrb,     // write strobes
    input  wire logic              s_axi_wvalid,    // write data valid
    output logic                   s_axi_wready,    // write data ready
    output logic [1:0]             s_axi_bresp,     // write response
    output logic                   s_axi_bvalid,    // write response valid
    input  wire logic              s_axi_bready,    // write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,    // read address
    input  wire logic              s_axi_arvalid,   // read address valid
    output logic                   s_axi_arready,   // read address ready
    output logic [31:0]            s_axi_rdata,     // read data
    output logic [1:0]             s_axi_rresp,     // read response
    output logic                   s_axi_rvalid,    // read data valid
    input  wire logic              s_axi_rready,    // read data ready
    input  wire logic              capture_compare_pin_in,   // pin level from outside
    output logic                   capture_compare_pin_out,  // pin drive level
    output logic                   capture_compare_pin_oe,   // pin driven in compare and pwm modes
    output logic                   conversion_start,         // pulse: start analog conversion
    input  wire logic              converter_enabled,        // converter on, same domain
    output logic                   unit_irq,                 // unit interrupt to processor
    output logic                   event_irq                 // masked sticky event interrupt
);
    typedef struct packed {
        logic [7:0]        val_lo;      // value_low_byte
        logic [7:0]        val_hi;      // value_high_byte
        logic [5:0]        control;     // unit_control bits 5-0
        logic [7:0]        irq_en;      // peripheral_irq_enable
        logic              global_peripheral_irq_enable;        // global_peripheral_irq_enable
        logic [7:0]        period;      // pwm_period_register
        logic [1:0]        tmr_run;     // timer run bits
        logic [15:0]       t16;         // sixteen_bit_timer_count
        logic              unit_flag;   // unit_irq_flag
        logic [EV_W-1:0]   ev_status;   // sticky event status
        logic [EV_W-1:0]   ev_mask;     // event mask
        logic [3:0]        prescale;    // capture edge prescaler
        logic [9:0]        duty_latch;  // duty latched at period start
        logic              pin;         // pin output level
        logic              oe;          // pin output enable
        logic              conv;        // conversion start pulse
        logic              irq;         // unit interrupt out
        logic              ev_irq;      // event interrupt out
        logic              aw_got;      // write address held
        logic              w_got;       // write data held
        logic [ADDR_W-1:0] awaddr;      // held write address
        logic [31:0]       wdata;       // held write data
        logic              wstrb0;      // held low byte strobe
        logic              bvalid;      // write response pending
        logic [1:0]        bresp;       // write response code
        logic              rvalid;      // read data pending
        logic [31:0]       rdata;       // read data
        logic [1:0]        rresp;       // read response code
    } state_t;
    state_t s_q, s_d;

    logic       pin_level;   // synchronised pin
    logic       pin_rise;    // synchronised rising edge
    logic       pin_fall;    // synchronised falling edge
    logic [7:0] t8_count;    // period timer count
    logic       t8_restart;  // period wrap pulse
    logic [3:0] mode;        // mode_select_field
    logic       is_pwm;      // 11xx
    logic       is_cmp;      // 10xx
    logic       is_cap;      // 01xx

    assign mode   = s_q.control[MODE_LSB +: 4];
    assign is_pwm = mode[3] & mode[2];
    assign is_cmp = mode[3] & ~mode[2];
    assign is_cap = ~mode[3] & mode[2];

    // pin passes two flops before any logic
    edge_sync u_sync (
        .clock (clock),
        .reset (reset),
        .pin   (capture_compare_pin_in),
        .level (pin_level),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    // pwm time base is the period timer
    period_timer #(.WIDTH(8)) u_t8 (
        .clock   (clock),
        .reset   (reset),
        .run     (s_q.tmr_run[T8_RUN_BIT]),
        .period  (s_q.period),
        .count   (t8_count),
        .restart (t8_restart)
    );

    // register read mux, unused bits read zero
    function automatic logic [31:0] read_word(input state_t st, input logic [7:0] idx,
                                              input logic [7:0] t8);
        logic [31:0] r;
        r = '0;
        case (idx)
            IDX_VALUE_LOW:     r[7:0] = st.val_lo;
            IDX_VALUE_HIGH:    r[7:0] = st.val_hi;
            IDX_UNIT_CONTROL:  r[5:0] = st.control;
            IDX_PERIPH_IRQ_EN: r[7:0] = st.irq_en;
            IDX_INTR_CONTROL:  r[GLOBAL_PERIPHERAL_IRQ_ENABLE_BIT] = st.global_peripheral_irq_enable;
            IDX_PERIOD:        r[7:0] = st.period;
            IDX_IRQ_STATUS:    r[EV_W-1:0] = st.ev_status;
            IDX_IRQ_MASK:      r[EV_W-1:0] = st.ev_mask;
            IDX_TIMER_CTRL:    r[1:0] = st.tmr_run;
            IDX_TIMER16:       r[15:0] = st.t16;
            IDX_TIMER8:        r[7:0] = t8;
            default:           r = '0;
        endcase
        return r;
    endfunction : read_word

    // known register index check
    function automatic logic mapped(input logic [7:0] idx);
        case (idx)
            IDX_VALUE_LOW, IDX_VALUE_HIGH, IDX_UNIT_CONTROL, IDX_PERIPH_IRQ_EN,
            IDX_INTR_CONTROL, IDX_PERIOD, IDX_IRQ_STATUS, IDX_IRQ_MASK,
            IDX_TIMER_CTRL, IDX_TIMER16, IDX_TIMER8: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : mapped

    // next-state logic: bus slave, timers, capture, compare, pwm, interrupts
    always_comb begin
        logic [7:0]       widx;       // write register index
        logic             wr_fire;    // write performed this cycle
        logic             match;      // timer equals value register
        logic             cap_ev;     // qualifying capture
        logic [EV_W-1:0]  ev_set;     // events this cycle
        logic [EV_W-1:0]  ev_clr;     // write-one-to-clear bits
        logic             flag_clr;   // software clears unit flag
        logic [9:0]       duty_now;   // programmed duty
        logic [9:0]       pwm_pos;    // position within period, 2 fine bits
        s_d      = s_q;
        widx     = '0;
        wr_fire  = 1'b0;
        match    = 1'b0;
        cap_ev   = 1'b0;
        ev_set   = '0;
        ev_clr   = '0;
        flag_clr = 1'b0;
        duty_now = {s_q.val_lo, s_q.control[DUTY_LSB_POS +: 2]};
        pwm_pos  = {t8_count, 2'b00};
        s_d.conv = 1'b0;

        // accept address and data in either order
        if (s_axi_awvalid && !s_q.aw_got) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got) begin
            s_d.w_got  = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb0 = s_axi_wstrb[0];
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // both halves held: perform write, raise response
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            widx       = s_q.awaddr[BYTE_SHIFT +: 8];
            wr_fire    = s_q.wstrb0 && (s_q.awaddr[ADDR_W-1:BYTE_SHIFT+8] == '0) && mapped(widx);
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = (mapped(widx) && s_q.awaddr[ADDR_W-1:BYTE_SHIFT+8] == '0) ? RESP_OKAY : RESP_SLVERR;
        end

        // read channel, one outstanding
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            if (s_axi_araddr[ADDR_W-1:BYTE_SHIFT+8] == '0 && mapped(s_axi_araddr[BYTE_SHIFT +: 8])) begin
                s_d.rdata = read_word(s_q, s_axi_araddr[BYTE_SHIFT +: 8], t8_count);
                s_d.rresp = RESP_OKAY;
            end else begin
                s_d.rdata = '0;
                s_d.rresp = RESP_SLVERR;
            end
        end

        if (s_q.tmr_run[T16_RUN_BIT]) begin
            s_d.t16 = s_q.t16 + 16'h0001;
        end
        // match only while timer runs
        match = s_q.tmr_run[T16_RUN_BIT] && (s_q.t16 == {s_q.val_hi, s_q.val_lo});

        if (mode == MODE_OFF) begin
            s_d.prescale   = '0;
            s_d.pin        = 1'b0;
            s_d.oe         = 1'b0;
            s_d.duty_latch = '0;
        end else if (is_cap) begin
            // pin released for capture
            s_d.oe = 1'b0;
            case (mode)
                MODE_CAP_FALL: cap_ev = pin_fall;
                MODE_CAP_RISE: cap_ev = pin_rise;
                MODE_CAP_RISE4: begin
                    if (pin_rise) begin
                        s_d.prescale = (s_q.prescale >= PRESCALE_4) ? 4'h0 : s_q.prescale + 4'h1;
                        cap_ev       = (s_q.prescale >= PRESCALE_4);
                    end
                end
                MODE_CAP_RISE16: begin
                    if (pin_rise) begin
                        s_d.prescale = s_q.prescale + 4'h1;
                        cap_ev       = (s_q.prescale == PRESCALE_16);
                    end
                end
                default: cap_ev = 1'b0;
            endcase
            if (cap_ev) begin
                s_d.val_lo = s_q.t16[7:0];
                s_d.val_hi = s_q.t16[15:8];
                ev_set[EV_CAPTURE] = 1'b1;
            end
        end else if (is_cmp) begin
            // unit drives pin on compare
            s_d.oe = 1'b1;
            if (match) begin
                ev_set[EV_MATCH] = 1'b1;
                case (mode)
                    MODE_CMP_SET: s_d.pin = 1'b1;
                    MODE_CMP_CLR: s_d.pin = 1'b0;
                    MODE_CMP_SOFT: s_d.pin = s_q.pin;
                    // special event: clear timer, start conversion when converter enabled
                    MODE_CMP_SPECIAL: begin
                        s_d.t16  = '0;
                        s_d.conv = converter_enabled;
                    end
                    default: s_d.pin = s_q.pin;
                endcase
            end
        end else begin
            // pwm: duty latched at each period start
            s_d.oe = 1'b1;
            if (t8_restart) begin
                s_d.duty_latch = duty_now;
                s_d.pin        = (duty_now != '0);
                ev_set[EV_PERIOD] = 1'b1;
            // duty beyond period never reached, pin stays high
            end else if (s_q.tmr_run[T8_RUN_BIT] && pwm_pos >= s_q.duty_latch) begin
                s_d.pin = 1'b0;
            end
        end

        // software writes, low byte lane only
        if (wr_fire) begin
            case (widx)
                IDX_VALUE_LOW:     s_d.val_lo = s_q.wdata[7:0];
                IDX_VALUE_HIGH:    s_d.val_hi = s_q.wdata[7:0];
                IDX_UNIT_CONTROL:  s_d.control = s_q.wdata[5:0] & CONTROL_WR_MASK[5:0];
                IDX_PERIPH_IRQ_EN: s_d.irq_en = s_q.wdata[7:0] & IRQ_EN_WR_MASK;
                IDX_INTR_CONTROL:  s_d.global_peripheral_irq_enable = s_q.wdata[GLOBAL_PERIPHERAL_IRQ_ENABLE_BIT];
                IDX_PERIOD:        s_d.period = s_q.wdata[7:0];
                IDX_IRQ_STATUS: begin
                    ev_clr   = s_q.wdata[EV_W-1:0];
                    flag_clr = s_q.wdata[EV_MATCH] | s_q.wdata[EV_CAPTURE];
                end
                IDX_IRQ_MASK:      s_d.ev_mask = s_q.wdata[EV_W-1:0];
                IDX_TIMER_CTRL:    s_d.tmr_run = s_q.wdata[1:0];
                default:           s_d.rdata = s_d.rdata;
            endcase
        end

        // sticky status, set wins over clear
        s_d.ev_status = (s_q.ev_status & ~ev_clr) | ev_set;
        s_d.unit_flag = (s_q.unit_flag & ~flag_clr) | ev_set[EV_MATCH] | ev_set[EV_CAPTURE];
        // unit flag gated by both enables
        s_d.irq    = s_d.unit_flag & s_d.irq_en[IRQ_EN_BIT] & s_d.global_peripheral_irq_enable;
        s_d.ev_irq = |(s_d.ev_status & s_d.ev_mask);
    end

    // control and enables reset to zero
    always_ff @(posedge clock) begin
        if (reset) begin
            s_q        <= '0;
            s_q.period <= PERIOD_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state flops
    assign s_axi_awready           = ~s_q.aw_got;
    assign s_axi_wready            = ~s_q.w_got;
    assign s_axi_bvalid            = s_q.bvalid;
    assign s_axi_bresp             = s_q.bresp;
    assign s_axi_arready           = ~s_q.rvalid;
    assign s_axi_rvalid            = s_q.rvalid;
    assign s_axi_rdata             = s_q.rdata;
    assign s_axi_rresp             = s_q.rresp;
    assign capture_compare_pin_out = s_q.pin;
    assign capture_compare_pin_oe  = s_q.oe;
    assign conversion_start        = s_q.conv;
    assign unit_irq                = s_q.irq;
    assign event_irq               = s_q.ev_irq;
endmodule : capture_compare_pwm_unit

// ==== src/ccp_pkg.sv ====
// package: register map, field layout, mode codes for the capture/compare/pwm unit
// assumes: 32-bit axi4-lite slave, one register per aligned word
package ccp_pkg;
    // printed offsets are not multiples of four: they are indices, byte address is index * 4
    localparam logic [7:0]  IDX_VALUE_LOW     = 8'h15;  // value_low_byte
    localparam logic [7:0]  IDX_VALUE_HIGH    = 8'h16;  // value_high_byte
    localparam logic [7:0]  IDX_UNIT_CONTROL  = 8'h17;  // unit_control
    localparam logic [7:0]  IDX_PERIPH_IRQ_EN = 8'h8C;  // peripheral_irq_enable
    localparam logic [7:0]  IDX_INTR_CONTROL  = 8'h0B;  // interrupt_control_register
    localparam logic [7:0]  IDX_PERIOD        = 8'h92;  // pwm_period_register
    localparam logic [7:0]  IDX_IRQ_STATUS    = 8'hC0;  // sticky event status
    localparam logic [7:0]  IDX_IRQ_MASK      = 8'hC1;  // event mask
    localparam logic [7:0]  IDX_TIMER_CTRL    = 8'hC2;  // timer run bits
    localparam logic [7:0]  IDX_TIMER16       = 8'hC3;  // sixteen_bit_timer_count, read only
    localparam logic [7:0]  IDX_TIMER8        = 8'hC4;  // period_timer_count, read only
    localparam int          ADDR_W            = 12;     // byte address width
    localparam int          BYTE_SHIFT        = 2;      // index to byte address
    // control field layout
    localparam int          MODE_LSB          = 0;
    localparam int          DUTY_LSB_POS      = 4;
    localparam logic [7:0]  CONTROL_WR_MASK   = 8'h3F;  // bits 7-6 unimplemented
    localparam int          IRQ_EN_BIT        = 2;      // unit_irq_enable
    localparam logic [7:0]  IRQ_EN_WR_MASK    = 8'h4F;  // implemented enable bits
    localparam int          GLOBAL_PERIPHERAL_IRQ_ENABLE_BIT          = 6;      // global_peripheral_irq_enable
    // event status bits
    localparam int          EV_MATCH          = 0;      // compare match
    localparam int          EV_CAPTURE        = 1;      // capture taken
    localparam int          EV_PERIOD         = 2;      // pwm period restart
    localparam int          EV_W              = 3;
    // timer control bits
    localparam int          T16_RUN_BIT       = 0;
    localparam int          T8_RUN_BIT        = 1;
    // mode codes
    localparam logic [3:0]  MODE_OFF          = 4'h0;
    localparam logic [3:0]  MODE_CAP_FALL     = 4'h4;
    localparam logic [3:0]  MODE_CAP_RISE     = 4'h5;
    localparam logic [3:0]  MODE_CAP_RISE4    = 4'h6;
    localparam logic [3:0]  MODE_CAP_RISE16   = 4'h7;
    localparam logic [3:0]  MODE_CMP_SET      = 4'h8;
    localparam logic [3:0]  MODE_CMP_CLR      = 4'h9;
    localparam logic [3:0]  MODE_CMP_SOFT     = 4'hA;
    localparam logic [3:0]  MODE_CMP_SPECIAL  = 4'hB;
    localparam logic [7:0]  PERIOD_RESET      = 8'hFF;  // period register reset value
    localparam logic [3:0]  PRESCALE_4        = 4'h3;   // last count of a 4-edge group
    localparam logic [3:0]  PRESCALE_16       = 4'hF;   // last count of a 16-edge group
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;
endpackage : ccp_pkg

// ==== src/edge_sync.sv ====
// two-flop synchroniser with rise/fall pulses on the settled level
// assumes: async pin input, single clock domain
`timescale 1ns/1ps
module edge_sync
    import ccp_pkg::*;
(
    input  wire logic clock,    // system clock
    input  wire logic reset,    // sync reset, high
    input  wire logic pin,      // asynchronous pin level
    output logic      level,    // synchronised level
    output logic      rise,     // one-cycle rising pulse
    output logic      fall      // one-cycle falling pulse
);
    typedef struct packed {
        logic meta;   // first flop, read only by second
        logic sync;   // second flop
        logic last;   // previous settled level
    } state_t;
    state_t s_q, s_d;

    // shift the pin through the chain
    always_comb begin
        s_d      = s_q;
        s_d.meta = pin;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
    end

    // register the chain
    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.sync;
    assign rise  = s_q.sync & ~s_q.last;
    assign fall  = ~s_q.sync & s_q.last;
endmodule : edge_sync

// ==== src/period_timer.sv ====
// 8-bit period-match timer: counts up, restarts after reaching the period
// assumes: period and run come from the register file in the same clock domain
`timescale 1ns/1ps
module period_timer
    import ccp_pkg::*;
#(
    parameter int WIDTH = 8     // counter width
)(
    input  wire logic             clock,    // system clock
    input  wire logic             reset,    // sync reset, high
    input  wire logic             run,      // count enable level
    input  wire logic [WIDTH-1:0] period,   // last count of a period
    output logic      [WIDTH-1:0] count,    // current count
    output logic                  restart   // pulse: new period starts next
);
    if (WIDTH < 2) begin : g_width
        $error("period_timer: WIDTH too small");
    end
    typedef struct packed {
        logic [WIDTH-1:0] cnt;   // running count
    } state_t;
    state_t s_q, s_d;

    // count and wrap on period match
    always_comb begin
        s_d = s_q;
        if (run) begin
            s_d.cnt = restart ? '0 : s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count   = s_q.cnt;
    assign restart = run && (s_q.cnt == period);
endmodule : period_timer

// ==== verification/ccp_checker.sv ====
// checker: bus handshake and output timing of the ccp unit
// assumes: bound to the unit top, one clock, sync reset
`timescale 1ns/1ps
module ccp_checker (
    input wire logic clock, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic conversion_start, unit_irq, event_irq, capture_compare_pin_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data unstable");
    property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_blk: assert property (p_ar_blk) else $error("arready while rvalid");
    property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_ans: assert property (p_r_ans) else $error("no read answer");
    property p_b_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_b_ans: assert property (p_b_ans) else $error("no write answer");
    property p_aw_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("awready stayed high");
    property p_conv; conversion_start |=> !conversion_start; endproperty
    a_conv: assert property (p_conv) else $error("start not a pulse");
    property p_rst; $fell(reset) |-> !unit_irq && !event_irq && !capture_compare_pin_oe; endproperty
    a_rst: assert property (p_rst) else $error("outputs live after reset");
endmodule : ccp_checker
bind capture_compare_pwm_unit ccp_checker chk_u (.clock(clock), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .conversion_start(conversion_start), .unit_irq(unit_irq),
    .event_irq(event_irq), .capture_compare_pin_oe(capture_compare_pin_oe));

// ==== verification/pin_source.sv ====
// partner: outside signal source on the capture/compare pin
// assumes: pin shows the unit's drive while its enable is high
`timescale 1ns/1ps
module pin_source (
    input  wire logic clock,  // system clock
    input  wire logic oe,     // unit drives pin
    input  wire logic out,    // unit drive level
    output logic      pin     // resolved pin level
);
    logic ext = 1'b0;  // outside level, idles low
    assign pin = oe ? out : ext;
    // n clean pulses, each long enough for the synchroniser
    task pulses(input int n);
        repeat (n) begin
            @(posedge clock) ext <= 1'b1;
            repeat (4) @(posedge clock);
            ext <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask : pulses
endmodule : pin_source

// ==== verification/capture_compare_pwm_unit_bench.sv ====
// testbench: register, capture, compare and pwm checks over axi4-lite
// assumes: 250 MHz clock, pin source partner on the pin
`timescale 1ns/1ps
module capture_compare_pwm_unit_bench;
    import ccp_pkg::*;
    logic clock = 0, reset = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, cen = 0, lo = 0, cs = 0;
    logic awr, wrd, bv, arr, rv, pin, pout, poe, conv, uirq, eirq;
    logic [ADDR_W-1:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat, got;
    logic [1:0] br, rr, rs;
    logic [15:0] v;
    logic [3:0] cm [4] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLR, MODE_CMP_SPECIAL};
    int pc [4] = '{1, 1, 4, 16};
    int miscompares = 0, num_checks = 0;
    always #2 clock = ~clock;
    always @(posedge clock) if (conv) cs <= 1'b1;
    capture_compare_pwm_unit dut_u (.clock(clock), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .capture_compare_pin_in(pin), .capture_compare_pin_out(pout), .capture_compare_pin_oe(poe),
        .conversion_start(conv), .converter_enabled(cen), .unit_irq(uirq), .event_irq(eirq));
    pin_source pin_u (.clock(clock), .oe(poe), .out(pout), .pin(pin));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task bus_wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clock);
        awa <= {2'b00, i, 2'b00};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clock);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
        chk("bresp", RESP_OKAY, br);
    endtask : bus_wr
    task bus_rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        ara <= {2'b00, i, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clock);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rry <= 1'b0;
        d = rdat;
        r = rr;
    endtask : bus_rd
    task rc(input logic [7:0] i, input logic [31:0] e);
        bus_rd(i, got, rs);
        chk($sformatf("reg %h", i), e, got);
    endtask : rc
    // status, both interrupt lines, then clear all
    task st(input logic [7:0] e);
        rc(IDX_IRQ_STATUS, {24'h0, e});
        chk("event_irq", e != 0, eirq);
        chk("unit_irq", e != 0, uirq);
        bus_wr(IDX_IRQ_STATUS, 8'hFF);
    endtask : st
    task pw(input logic [7:0] d, input logic e);
        bus_wr(IDX_VALUE_LOW, d);
        repeat (60) @(posedge clock);
        lo = 1'b0;
        repeat (60) begin
            @(posedge clock);
            if (pout !== 1'b1) lo = 1'b1;
        end
        chk("pwm_low", e, lo);
    endtask : pw
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    initial begin
        repeat (30000) @(posedge clock);
        miscompares++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rc(IDX_UNIT_CONTROL, 32'h0);
        rc(IDX_PERIPH_IRQ_EN, 32'h0);
        bus_wr(IDX_UNIT_CONTROL, 8'hF0);
        rc(IDX_UNIT_CONTROL, 32'h30);
        bus_wr(IDX_VALUE_LOW, 8'hA5);
        bus_wr(IDX_VALUE_HIGH, 8'h5A);
        rc(IDX_VALUE_LOW, 32'hA5);
        rc(IDX_VALUE_HIGH, 32'h5A);
        bus_rd(8'h50, got, rs);
        chk("unmapped", RESP_SLVERR, rs);
        bus_wr(IDX_TIMER_CTRL, 8'h01);
        bus_wr(IDX_PERIPH_IRQ_EN, 8'h04);
        bus_wr(IDX_INTR_CONTROL, 8'h40);
        bus_wr(IDX_IRQ_MASK, 8'h03);
        cen <= 1'b1;
        // capture modes: one edge short of the group, then the last edge
        for (int k = 0; k < 4; k++) begin
            bus_wr(IDX_UNIT_CONTROL, 8'(4 + k));
            pin_u.pulses(pc[k] - 1);
            st(8'h00);
            pin_u.pulses(1);
            st(8'h02);
            bus_wr(IDX_UNIT_CONTROL, 8'(MODE_OFF));
        end
        bus_wr(IDX_UNIT_CONTROL, 8'h05);
        pin_u.pulses(1);
        bus_wr(IDX_PERIPH_IRQ_EN, 8'h00);
        chk("irq_en", 1'b0, uirq);
        bus_wr(IDX_PERIPH_IRQ_EN, 8'h04);
        bus_wr(IDX_INTR_CONTROL, 8'h00);
        chk("global_peripheral_irq_enable", 1'b0, uirq);
        bus_wr(IDX_INTR_CONTROL, 8'h40);
        st(8'h02);
        // compare modes: match 400 counts ahead
        for (int k = 0; k < 4; k++) begin
            bus_rd(IDX_TIMER16, got, rs);
            v = got[15:0] + 16'd400;
            bus_wr(IDX_VALUE_LOW, v[7:0]);
            bus_wr(IDX_VALUE_HIGH, v[15:8]);
            bus_wr(IDX_UNIT_CONTROL, {4'h0, cm[k]});
            repeat (600) @(posedge clock);
            chk("pin_out", k < 2, pout);
            chk("pin_oe", 1'b1, poe);
            st(8'h01);
        end
        chk("conv", 1'b1, cs);
        bus_rd(IDX_TIMER16, got, rs);
        chk("timer_clr", 1'b1, got[15:0] < 16'd400);
        bus_wr(IDX_TIMER_CTRL, 8'h03);
        bus_wr(IDX_PERIOD, 8'h10);
        bus_wr(IDX_UNIT_CONTROL, 8'h3C);
        pw(8'hFF, 1'b0);
        pw(8'h02, 1'b1);
        final_report;
    end
endmodule : capture_compare_pwm_unit_bench
